// *** core/pll_divider_control_regs.sv ***
// Purpose: pll control registers, mode decode and the two dividers
// Assumes: register port is the serial port's internal byte access
// Notes: prescaler ratio is a parameter; counter resets not modelled
`include "pll_regs_map.svh"

module pll_divider_control_regs #(
    parameter int ADDR_W = 10,
    parameter int DIV_W = 20,
    parameter int PRESCALE = 32
) (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    // register access from the serial control port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // clock events to divide
    input wire logic ref_tick,
    input wire logic fb_tick,
    // divider outputs
    output logic ref_div_pulse,
    output logic fb_div_pulse,
    // charge pump controls
    output logic cp_hiz,
    output logic cp_force_source,
    output logic cp_force_sink,
    output logic cp_normal,
    // power state
    output logic pll_pd_async,
    output logic pll_pd_sync,
    output logic pll_running
);

    // feedback ratio: prescaler times b plus a
    function automatic logic [DIV_W-1:0] fb_ratio(
        input logic [12:0] b_val,
        input logic [5:0] a_val
    );
        logic [31:0] prod;
        prod = PRESCALE * 32'(b_val) + 32'(a_val);
        return prod[DIV_W-1:0];
    endfunction

    // reset release through two flops
    logic rst_meta_reg;
    logic rst_sync_reg;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // stored registers
    pll_regs_pkg::reg_byte_t ctrl_main_reg; // pump and power modes
    logic [7:0] ref_low_reg; // reference divider low
    logic [`REF_HIGH_W-1:0] ref_high_reg; // reference divider high
    logic [`SWALLOW_W-1:0] swallow_reg; // a counter
    logic [7:0] fb_low_reg; // b counter low
    logic [`FB_HIGH_W-1:0] fb_high_reg; // b counter high
    pll_regs_pkg::reg_byte_t ctrl_cnt_reg; // counter control byte

    // address decode
    wire sel_main = (reg_addr == `ADDR_CTRL_MAIN);
    wire sel_ref_low = (reg_addr == `ADDR_REF_LOW);
    wire sel_ref_high = (reg_addr == `ADDR_REF_HIGH);
    wire sel_swallow = (reg_addr == `ADDR_SWALLOW);
    wire sel_fb_low = (reg_addr == `ADDR_FB_LOW);
    wire sel_fb_high = (reg_addr == `ADDR_FB_HIGH);
    wire sel_cnt = (reg_addr == `ADDR_CTRL_CNT);

    // register writes
    always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            ctrl_main_reg <= `RST_CTRL_MAIN;
            ref_low_reg <= `RST_REF_LOW;
            ref_high_reg <= `REF_HIGH_W'(`RST_REF_HIGH);
            swallow_reg <= `SWALLOW_W'(`RST_SWALLOW);
            fb_low_reg <= `RST_FB_LOW;
            fb_high_reg <= `FB_HIGH_W'(`RST_FB_HIGH);
            ctrl_cnt_reg <= `RST_CTRL_CNT;
        end else if (ce && reg_wr) begin
            if (sel_main) ctrl_main_reg <= reg_wdata;
            if (sel_ref_low) ref_low_reg <= reg_wdata;
            // upper bits of narrow fields are dropped
            if (sel_ref_high) begin
                ref_high_reg <= reg_wdata[`REF_HIGH_W-1:0];
            end
            if (sel_swallow) begin
                swallow_reg <= reg_wdata[`SWALLOW_W-1:0];
            end
            if (sel_fb_low) fb_low_reg <= reg_wdata;
            if (sel_fb_high) begin
                fb_high_reg <= reg_wdata[`FB_HIGH_W-1:0];
            end
            if (sel_cnt) ctrl_cnt_reg <= reg_wdata;
        end
    end

    // read data selection, narrow fields zero-extended
    wire [7:0] rd_mux =
        sel_main ? ctrl_main_reg :
        sel_ref_low ? ref_low_reg :
        sel_ref_high ? 8'(ref_high_reg) :
        sel_swallow ? 8'(swallow_reg) :
        sel_fb_low ? fb_low_reg :
        sel_fb_high ? 8'(fb_high_reg) :
        sel_cnt ? ctrl_cnt_reg : `RDATA_NONE;

    // field views
    wire [1:0] cp_bits = ctrl_main_reg[`CHARGE_PUMP_MODE_MSB:`CHARGE_PUMP_MODE_LSB];
    wire [1:0] pd_bits = ctrl_main_reg[`PD_MODE_MSB:`PD_MODE_LSB];
    pll_regs_pkg::charge_pump_mode_e charge_pump_mode;
    pll_regs_pkg::pd_mode_e pd_mode;
    assign charge_pump_mode = pll_regs_pkg::charge_pump_mode_e'(cp_bits);
    assign pd_mode = pll_regs_pkg::pd_mode_e'(pd_bits);

    // assembled divider values
    wire [13:0] ref_value = {ref_high_reg, ref_low_reg};
    wire [12:0] fb_value = {fb_high_reg, fb_low_reg};

    // divider carriers
    div_cfg_if #(.DIV_W(DIV_W)) ref_cfg ();
    div_cfg_if #(.DIV_W(DIV_W)) fb_cfg ();

    // dividers held while the loop is down
    logic hold_reg;
    logic hold_next;

    // power-down: async holds at once, sync waits for a reference divider pulse
    always_comb begin
        case (pd_mode)
            pll_regs_pkg::PD_NORMAL: hold_next = 1'b0;
            pll_regs_pkg::PD_ASYNC: hold_next = 1'b1;
            pll_regs_pkg::PD_SYNC: begin
                hold_next = hold_reg | ref_cfg.pulse;
            end
            // undefined code keeps the loop down
            default: hold_next = 1'b1;
        endcase
    end

    assign ref_cfg.hold = hold_reg;
    assign ref_cfg.ratio = DIV_W'(ref_value);
    assign ref_cfg.tick = ref_tick;
    assign fb_cfg.hold = hold_reg;
    assign fb_cfg.ratio = fb_ratio(fb_value, swallow_reg);
    assign fb_cfg.tick = fb_tick;

    tick_divider #(.DIV_W(DIV_W)) u_ref_div (
        .ref_clk(ref_clk),
        .rst_n(rst_sync_reg),
        .ce(ce),
        .cfg(ref_cfg)
    );

    tick_divider #(.DIV_W(DIV_W)) u_fb_div (
        .ref_clk(ref_clk),
        .rst_n(rst_sync_reg),
        .ce(ce),
        .cfg(fb_cfg)
    );

    // output flops: read data, pump and power decode
    always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            hold_reg <= 1'b1;
            reg_rdata <= `RDATA_NONE;
            ref_div_pulse <= 1'b0;
            fb_div_pulse <= 1'b0;
            cp_hiz <= 1'b0;
            cp_force_source <= 1'b0;
            cp_force_sink <= 1'b0;
            cp_normal <= 1'b0;
            pll_pd_async <= 1'b0;
            pll_pd_sync <= 1'b0;
            pll_running <= 1'b0;
        end else if (ce) begin
            hold_reg <= hold_next;
            if (reg_rd) reg_rdata <= rd_mux;
            ref_div_pulse <= ref_cfg.pulse;
            fb_div_pulse <= fb_cfg.pulse;
            cp_hiz <= (charge_pump_mode == pll_regs_pkg::CP_HIZ);
            cp_force_source <= (charge_pump_mode == pll_regs_pkg::CP_FORCE_SOURCE);
            cp_force_sink <= (charge_pump_mode == pll_regs_pkg::CP_FORCE_SINK);
            cp_normal <= (charge_pump_mode == pll_regs_pkg::CP_NORMAL);
            pll_pd_async <= (pd_mode == pll_regs_pkg::PD_ASYNC);
            pll_pd_sync <= (pd_mode == pll_regs_pkg::PD_SYNC);
            pll_running <= !hold_reg;
        end
    end

endmodule

// *** pkg/pll_regs_map.svh ***
// Purpose: addresses, reset values and field positions of the pll bank
// Assumes: register addresses as printed, 8-bit data
// Notes: definitions only
// Behaviour
// - charge pump mode field, reset normal pumping
// - pll power-down field, reset asynchronous power-down
// - 14-bit reference divider, low reset one
// - 6-bit swallow counter, reset zero
// - 13-bit feedback counter, low reset three
`ifndef PLL_REGS_MAP_SVH
`define PLL_REGS_MAP_SVH

// register addresses
`define ADDR_CTRL_MAIN 10'h010
`define ADDR_REF_LOW 10'h011
`define ADDR_REF_HIGH 10'h012
`define ADDR_SWALLOW 10'h013
`define ADDR_FB_LOW 10'h014
`define ADDR_FB_HIGH 10'h015
`define ADDR_CTRL_CNT 10'h016

// reset values
`define RST_CTRL_MAIN 8'h7D
`define RST_REF_LOW 8'h01
`define RST_REF_HIGH 8'h00
`define RST_SWALLOW 8'h00
`define RST_FB_LOW 8'h03
`define RST_FB_HIGH 8'h00
`define RST_CTRL_CNT 8'h06

// field positions and widths
`define CHARGE_PUMP_MODE_MSB 3
`define CHARGE_PUMP_MODE_LSB 2
`define PD_MODE_MSB 1
`define PD_MODE_LSB 0
`define REF_HIGH_W 6
`define SWALLOW_W 6
`define FB_HIGH_W 5

// answer for an unmapped address
`define RDATA_NONE 8'h00

`endif

// *** pkg/pll_regs_pkg.sv ***
// Purpose: types used by the pll register bank for its bytes and mode fields
// Assumes: enum order matches the two-bit field encodings
// Notes: nothing here is imported; users write the package name
package pll_regs_pkg;

    // charge pump operating mode, in field encoding order
    typedef enum logic [1:0] {
        CP_HIZ,
        CP_FORCE_SOURCE,
        CP_FORCE_SINK,
        CP_NORMAL
    } charge_pump_mode_e;

    // pll power-down mode, in field encoding order
    typedef enum logic [1:0] {
        PD_NORMAL,
        PD_ASYNC,
        PD_UNUSED,
        PD_SYNC
    } pd_mode_e;

    // register data word
    typedef logic [7:0] reg_byte_t;

endpackage

// *** pkg/div_cfg_if.sv ***
// Purpose: carries ratio, hold and tick between the bank and a divider
// Assumes: single clock domain
// Notes: pulse is driven by the divider, the rest by the bank
interface div_cfg_if #(
    parameter int DIV_W = 20
);
    logic hold; // keep counter cleared
    logic [DIV_W-1:0] ratio; // division ratio, zero treated as one
    logic tick; // input event to count
    logic pulse; // one pulse per ratio ticks

    // bank side
    modport ctrl (
        output hold,
        output ratio,
        output tick,
        input pulse
    );

    // divider side
    modport div (
        input hold,
        input ratio,
        input tick,
        output pulse
    );
endinterface

// *** core/tick_divider.sv ***
// Purpose: counts input ticks and emits one pulse per programmed ratio
// Assumes: ticks are synchronous one-cycle enables on ref_clk
// Notes: a ratio of zero divides by one
module tick_divider #(
    parameter int DIV_W = 20
) (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    // configuration and event carrier
    div_cfg_if.div cfg
);

    logic [DIV_W-1:0] count_reg; // ticks seen in this period
    logic [DIV_W-1:0] count_next;
    logic pulse_reg; // output pulse flop
    logic pulse_next;
    wire [DIV_W-1:0] last_count; // count at which the period ends
    wire wrap; // this tick closes the period

    // zero ratio behaves as divide-by-one
    assign last_count = (cfg.ratio == '0) ? '0 : cfg.ratio - 1'b1;
    assign wrap = cfg.tick && (count_reg >= last_count);

    // next state of counter and pulse
    always_comb begin
        count_next = count_reg;
        pulse_next = 1'b0;
        if (cfg.hold) begin
            // held counters restart from zero
            count_next = '0;
        end else if (wrap) begin
            count_next = '0;
            pulse_next = 1'b1;
        end else if (cfg.tick) begin
            count_next = count_reg + 1'b1;
        end
    end

    // state flops, frozen while ce is low
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= '0;
            pulse_reg <= 1'b0;
        end else if (ce) begin
            count_reg <= count_next;
            pulse_reg <= pulse_next;
        end
    end

    assign cfg.pulse = pulse_reg;

endmodule

// *** verification/pll_divider_control_regs_props.sv ***
// Purpose: port-level checks of the pll register bank
// Assumes: strobes and ticks count only with ce high
// Notes: bound to the top module after the module
`include "pll_regs_map.svh"
module pll_divider_control_regs_props #(
    parameter int ADDR_W = 10
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // register port
    input wire logic ce,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // divider events
    input wire logic ref_tick,
    input wire logic fb_tick,
    input wire logic ref_div_pulse,
    input wire logic fb_div_pulse,
    // decoded controls
    input wire logic cp_hiz,
    input wire logic cp_force_source,
    input wire logic cp_force_sink,
    input wire logic cp_normal,
    input wire logic pll_pd_async,
    input wire logic pll_pd_sync,
    input wire logic pll_running
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // taken write to the main control byte, and its fields
    wire ctrl_wr = ce && reg_wr && reg_addr == `ADDR_CTRL_MAIN;
    wire [1:0] wr_cp = reg_wdata[3:2];
    wire [1:0] wr_pd = reg_wdata[1:0];
    wire [3:0] cp_vec = {cp_normal, cp_force_sink, cp_force_source, cp_hiz};
    // previous cycle's write, for write-then-read checks
    logic last_wr_reg;
    logic [ADDR_W-1:0] last_addr_reg;
    logic [7:0] last_data_reg;
    // bits a register keeps; unused upper bits read back zero
    function automatic logic [7:0] kept(input logic [ADDR_W-1:0] a);
        case (a)
            `ADDR_REF_HIGH, `ADDR_SWALLOW: kept = 8'h3f;
            `ADDR_FB_HIGH: kept = 8'h1f;
            default: kept = 8'hff;
        endcase
    endfunction
    wire rb_hit = ce && reg_rd && !reg_wr && last_wr_reg
        && reg_addr == last_addr_reg;
    wire [7:0] rb_exp = last_data_reg & kept(last_addr_reg);
    // remember each write strobe
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            last_wr_reg <= 1'b0;
            last_addr_reg <= '0;
            last_data_reg <= 8'h00;
        end else begin
            last_wr_reg <= ce && reg_wr;
            last_addr_reg <= reg_addr;
            last_data_reg <= reg_wdata;
        end
    end
    property p_charge_pump_mode;
        ctrl_wr ##1 ce |=> cp_vec == 4'h1 << $past(wr_cp, 2);
    endproperty
    a_charge_pump_mode: assert property (p_charge_pump_mode)
        else $error("pump mode decode wrong");
    property p_pd_mode;
        ctrl_wr ##1 ce |=> {pll_pd_sync, pll_pd_async} ==
            {$past(wr_pd, 2) == 2'b11, $past(wr_pd, 2) == 2'b01};
    endproperty
    a_pd_mode: assert property (p_pd_mode)
        else $error("power-down decode wrong");
    property p_running;
        ctrl_wr && wr_pd != 2'b11 ##1 (ce && !ctrl_wr)[*2]
            |=> pll_running == ($past(wr_pd, 3) == 2'b00);
    endproperty
    a_running: assert property (p_running)
        else $error("run state wrong");
    property p_ref_rb;
        rb_hit && reg_addr inside {`ADDR_REF_LOW, `ADDR_REF_HIGH}
            |=> reg_rdata == $past(rb_exp);
    endproperty
    a_ref_rb: assert property (p_ref_rb)
        else $error("reference divider readback wrong");
    property p_swallow_rb;
        rb_hit && reg_addr == `ADDR_SWALLOW |=> reg_rdata == $past(rb_exp);
    endproperty
    a_swallow_rb: assert property (p_swallow_rb)
        else $error("swallow counter readback wrong");
    property p_fb_rb;
        rb_hit && reg_addr inside {`ADDR_FB_LOW, `ADDR_FB_HIGH}
            |=> reg_rdata == $past(rb_exp);
    endproperty
    a_fb_rb: assert property (p_fb_rb)
        else $error("feedback counter readback wrong");
    property p_ref_pulse;
        ref_div_pulse && $past(ce) && $past(ce, 2) |-> $past(ref_tick, 2);
    endproperty
    a_ref_pulse: assert property (p_ref_pulse)
        else $error("reference pulse without tick");
    property p_fb_pulse;
        fb_div_pulse && $past(ce) && $past(ce, 2) |-> $past(fb_tick, 2);
    endproperty
    a_fb_pulse: assert property (p_fb_pulse)
        else $error("feedback pulse without tick");
    // main scenarios reached
    c_ctrl: cover property (ctrl_wr ##1 ce[*2]);
    c_rb: cover property (rb_hit);
    c_pulses: cover property (ref_div_pulse ##[1:80] fb_div_pulse);
endmodule

bind pll_divider_control_regs pll_divider_control_regs_props #(
    .ADDR_W(ADDR_W)
) u_props (.ref_clk, .rst_n, .ce, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .ref_tick, .fb_tick, .ref_div_pulse, .fb_div_pulse, .cp_hiz,
    .cp_force_source, .cp_force_sink, .cp_normal, .pll_pd_async,
    .pll_pd_sync, .pll_running);

// *** verification/test_pll_divider_control_regs.sv ***
// Purpose: self-checking bench for the pll register bank
// Assumes: default parameters, prescaler ratio 32
// Notes: inputs change by non-blocking assignment at rising edges
module test_pll_divider_control_regs;
    timeunit 1ns;
    timeprecision 1ps;
    // stimulus
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic [9:0] reg_addr = 10'h000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic ref_tick = 1'b0;
    logic fb_tick = 1'b0;
    // observed outputs
    logic [7:0] reg_rdata;
    logic ref_div_pulse, fb_div_pulse, cp_hiz, cp_force_source;
    logic cp_force_sink, cp_normal, pll_pd_async, pll_pd_sync, pll_running;
    // bookkeeping
    int failures = 0;
    int n_checks = 0;
    int n_ref = 0;
    int n_fb = 0;
    pll_divider_control_regs dut (.ref_clk, .rst_n, .ce, .reg_addr, .reg_wr,
        .reg_rd, .reg_wdata, .reg_rdata, .ref_tick, .fb_tick, .ref_div_pulse,
        .fb_div_pulse, .cp_hiz, .cp_force_source, .cp_force_sink, .cp_normal,
        .pll_pd_async, .pll_pd_sync, .pll_running);
    // 25 MHz clock
    always #20 ref_clk = ~ref_clk;
    // count divider output pulses
    always @(posedge ref_clk) begin
        if (ref_div_pulse === 1'b1) n_ref++;
        if (fb_div_pulse === 1'b1) n_fb++;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h",
                $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // write then read the same place on the very next cycle
    task automatic wr_rd(input logic [9:0] a, input logic [7:0] v,
        output logic [7:0] d);
        wr(a, v);
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        d = reg_rdata;
    endtask
    task automatic rd(input logic [9:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        d = reg_rdata;
    endtask
    // both tick inputs high for n sampled edges, pulse counts cleared
    task automatic ticks(input int n);
        @(negedge ref_clk);
        n_ref = 0;
        n_fb = 0;
        @(posedge ref_clk);
        ref_tick <= 1'b1;
        fb_tick <= 1'b1;
        repeat (n) @(posedge ref_clk);
        ref_tick <= 1'b0;
        fb_tick <= 1'b0;
        repeat (4) @(negedge ref_clk);
    endtask
    task automatic t_reset();
        logic [7:0] exp [7] = '{8'h7d, 8'h01, 8'h00, 8'h00, 8'h03, 8'h00,
            8'h06};
        logic [7:0] d;
        chk({1'b0, cp_normal, cp_force_sink, cp_force_source, cp_hiz,
            pll_pd_sync, pll_pd_async, pll_running}, 8'h42);
        for (int i = 0; i < 7; i++) begin
            rd(10'h010 + 10'(i), d);
            chk(d, exp[i]);
        end
    endtask
    task automatic t_modes();
        logic [3:0] m;
        for (int i = 0; i < 16; i++) begin
            m = 4'(i);
            wr(10'h010, {4'h7, m});
            repeat (3) @(negedge ref_clk);
            chk({4'h0, cp_normal, cp_force_sink, cp_force_source, cp_hiz},
                8'h01 << m[3:2]);
            chk({6'h00, pll_pd_sync, pll_pd_async},
                {6'h00, m[1:0] == 2'b11, m[1:0] == 2'b01});
            if (m[1:0] != 2'b11) chk({7'h00, pll_running},
                {7'h00, m[1:0] == 2'b00});
        end
    endtask
    task automatic t_regs();
        logic [9:0] adr [6] = '{10'h011, 10'h012, 10'h013, 10'h014, 10'h015,
            10'h017};
        logic [7:0] kept [6] = '{8'hff, 8'h3f, 8'h3f, 8'hff, 8'h1f, 8'h00};
        logic [7:0] d;
        for (int i = 0; i < 6; i++) begin
            wr_rd(adr[i], 8'hff, d);
            chk(d, kept[i]);
        end
        // a write while the clock enable is low is ignored
        @(posedge ref_clk);
        ce <= 1'b0;
        wr(10'h011, 8'h5a);
        ce <= 1'b1;
        rd(10'h011, d);
        chk(d, 8'hff);
    endtask
    task automatic t_div();
        wr(10'h011, 8'h03);
        wr(10'h012, 8'h00);
        wr(10'h013, 8'h01);
        wr(10'h014, 8'h01);
        wr(10'h015, 8'h00);
        wr(10'h010, 8'h7c);
        repeat (4) @(posedge ref_clk);
        ticks(66);
        chk(8'(n_ref), 8'h16);
        chk(8'(n_fb), 8'h02);
        // asynchronous power-down stops both dividers
        wr(10'h010, 8'h7d);
        repeat (3) @(posedge ref_clk);
        ticks(66);
        chk(8'(n_ref + n_fb), 8'h00);
        // synchronous power-down keeps running until a reference pulse
        wr(10'h010, 8'h7c);
        wr(10'h010, 8'h7f);
        repeat (3) @(negedge ref_clk);
        chk({7'h00, pll_running}, 8'h01);
        ticks(66);
        chk(8'(n_ref), 8'h01);
        chk(8'(n_fb), 8'h00);
        chk({7'h00, pll_running}, 8'h00);
    endtask
    task automatic summarize();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // watchdog against a hang
    initial begin
        #200000;
        failures++;
        summarize();
    end
    // main sequence
    initial begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(negedge ref_clk);
        t_reset();
        t_modes();
        t_regs();
        t_div();
        summarize();
    end
endmodule
